/* verilog/pin_sharing_pkg.sv */
// Shared constants and types for the serial and clock pin sharing block
package pin_sharing_pkg;

    // Number of shared pins handled by the block
    localparam int PIN_COUNT = 6;

    // Pin positions on the pin vectors
    localparam int IDX_PORT2_BIT2 = 0; // Serial data-out pin
    localparam int IDX_PORT2_BIT3 = 1; // Serial data-in pin
    localparam int IDX_PORT2_BIT4 = 2; // Slave select pin
    localparam int IDX_PORT2_BIT5 = 3; // Serial clock pin
    localparam int IDX_PORT3_BIT0 = 4; // Amplifier output or divided clock
    localparam int IDX_PORT3_BIT1 = 5; // Oscillator input pin

    // Oscillator trim register layout
    localparam int TRIM_WIDTH = 8;
    localparam int TRIM_CLOCK_OUTPUT_ENABLE_BIT = 6;

    // Output type of a port pin
    typedef enum logic [1:0] {
        MODE_QUASI,
        MODE_PUSH_PULL,
        MODE_INPUT_ONLY,
        MODE_OPEN_DRAIN
    } port_mode_t;

    // CPU clock source chosen by the flash configuration
    typedef enum logic [1:0] {
        CLK_INTERNAL_RC,
        CLK_WATCHDOG,
        CLK_EXTERNAL_INPUT,
        CLK_CRYSTAL
    } clk_src_t;

    // One port latch: output type and output data
    typedef struct packed {
        port_mode_t mode;
        logic data;
    } pin_ctl_t;

    // Signals from the serial unit toward the pins
    typedef struct packed {
        logic enable;
        logic master;
        logic data_out;
        logic data_in_drive;
        logic clock_out;
    } spi_ctl_t;

    // Latch value while and after reset: input only, pull-up off
    localparam pin_ctl_t PIN_CTL_RESET = '{mode: MODE_INPUT_ONLY, data: 1'b1};

endpackage

/* verilog/pin_mux_cell.sv */
// One pin driver: port output type or alternate function override
module pin_mux_cell
    import pin_sharing_pkg::*;
(
    input wire pin_ctl_t latch,
    input wire logic alt_en,
    input wire logic alt_drive,
    input wire logic alt_value,
    output logic out,
    output logic oe,
    output logic pull_en
);

    // Alternate function first, else general port behaviour
    always_comb begin
        out = 1'b0;
        oe = 1'b0;
        pull_en = 1'b0;
        if (alt_en) begin
            // Alternate owns the pin; driven or input only
            out = alt_value;
            oe = alt_drive;
        end else begin
            case (latch.mode)
                MODE_QUASI: begin
                    // Weak pull-up, strong drive only for low
                    pull_en = 1'b1;
                    oe = ~latch.data;
                end
                MODE_PUSH_PULL: begin
                    out = latch.data;
                    oe = 1'b1;
                end
                MODE_OPEN_DRAIN: begin
                    // Only pulls low
                    oe = ~latch.data;
                end
                default: begin
                    // Input only: no drive and no pull-up
                    oe = 1'b0;
                end
            endcase
        end
    end

endmodule

/* verilog/spi_and_clock_pin_sharing.sv */
// Top of the serial and clock pin sharing block
// Overview of operation
// - Data-in pin: input as master, output as slave
// - Clock pin: output as master, input as slave
// - Data-out pin: output as master, input as slave
// - Two port 3 latches reset input-only, no pull-up
// - Each pin keeps its own output type
// - Clock output enable puts clock/2 on bit0
// - Divided clock blocked when crystal drives system timer
// - Crystal option drives amplifier output on bit0
// - Bit1 oscillator input; port only on RC/watchdog
// - Slave select is input only beside port use
module spi_and_clock_pin_sharing
    import pin_sharing_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [PIN_COUNT-1:0] PIN_IN,
    output logic [PIN_COUNT-1:0] PIN_OUT,
    output logic [PIN_COUNT-1:0] PIN_OE,
    output logic [PIN_COUNT-1:0] PIN_PULLUP,
    output logic [PIN_COUNT-1:0] PIN_READ,
    input wire logic [PIN_COUNT-1:0] PORT_WR,
    input wire pin_ctl_t PORT_WDATA,
    input wire spi_ctl_t SPI_CTL,
    output logic SPI_DATA_OUT_IN,
    output logic SPI_DATA_IN_IN,
    output logic SPI_CLOCK_IN,
    output logic SPI_SELECT_N_IN,
    input wire logic [TRIM_WIDTH-1:0] OSC_TRIM,
    input wire clk_src_t CPU_CLOCK_SOURCE,
    input wire logic RTC_FROM_CRYSTAL,
    input wire logic OSC_AMP_OUT,
    output logic OSC_INPUT,
    output logic CLOCK_OUTPUT_ACTIVE
);

    // Port latches, one per shared pin
    pin_ctl_t latch [PIN_COUNT];
    pin_ctl_t next_latch [PIN_COUNT];

    // Alternate function requests per pin
    logic [PIN_COUNT-1:0] alt_en;
    logic [PIN_COUNT-1:0] alt_drive;
    logic [PIN_COUNT-1:0] alt_value;

    // Pin drive before the output flops
    logic [PIN_COUNT-1:0] next_pin_out;
    logic [PIN_COUNT-1:0] next_pin_oe;
    logic [PIN_COUNT-1:0] next_pin_pullup;

    // Output flops
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic [PIN_COUNT-1:0] pin_pullup;
    logic [PIN_COUNT-1:0] pin_read;
    logic spi_data_out_in;
    logic spi_data_in_in;
    logic spi_clock_in;
    logic spi_select_n_in;
    logic osc_input;
    logic divided_clock_output_active;

    // Clock divider state
    logic div_clk;
    logic next_div_clk;

    // Decoded clock situation
    logic clock_output_enable;
    logic crystal_active;
    logic osc_input_sel;
    logic divided_clock_output_sel;

    // Marks the first clock edge after reset release
    logic fresh;

    // Clock situation from trim bit and flash configuration
    always_comb begin
        clock_output_enable = OSC_TRIM[TRIM_CLOCK_OUTPUT_ENABLE_BIT];
        // Amplifier runs for a crystal CPU clock or crystal system timer
        crystal_active = (CPU_CLOCK_SOURCE == CLK_CRYSTAL) || RTC_FROM_CRYSTAL;
        // Oscillator input in use unless RC or watchdog and no crystal timer
        osc_input_sel = !((CPU_CLOCK_SOURCE == CLK_INTERNAL_RC ||
                           CPU_CLOCK_SOURCE == CLK_WATCHDOG) && !RTC_FROM_CRYSTAL);
        // Divided clock only when no crystal feeds anything
        divided_clock_output_sel = clock_output_enable && !crystal_active;
    end

    // Latch writes, each pin on its own strobe
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_latch[i] = PORT_WR[i] ? PORT_WDATA : latch[i];
        end
    end

    // Alternate function claims per pin
    always_comb begin
        alt_en = '0;
        alt_drive = '0;
        alt_value = '0;
        // Data-out pin drives only as master
        alt_en[IDX_PORT2_BIT2] = SPI_CTL.enable;
        alt_drive[IDX_PORT2_BIT2] = SPI_CTL.master;
        alt_value[IDX_PORT2_BIT2] = SPI_CTL.data_out;
        // Data-in pin drives only as slave
        alt_en[IDX_PORT2_BIT3] = SPI_CTL.enable;
        alt_drive[IDX_PORT2_BIT3] = !SPI_CTL.master;
        alt_value[IDX_PORT2_BIT3] = SPI_CTL.data_in_drive;
        // Slave select never claims the pin; it is only sampled
        alt_en[IDX_PORT2_BIT4] = 1'b0;
        // Clock pin drives only as master
        alt_en[IDX_PORT2_BIT5] = SPI_CTL.enable;
        alt_drive[IDX_PORT2_BIT5] = SPI_CTL.master;
        alt_value[IDX_PORT2_BIT5] = SPI_CTL.clock_out;
        // Bit0: amplifier output wins, then divided clock
        if (crystal_active) begin
            alt_en[IDX_PORT3_BIT0] = 1'b1;
            alt_drive[IDX_PORT3_BIT0] = 1'b1;
            alt_value[IDX_PORT3_BIT0] = OSC_AMP_OUT;
        end else if (divided_clock_output_sel) begin
            alt_en[IDX_PORT3_BIT0] = 1'b1;
            alt_drive[IDX_PORT3_BIT0] = 1'b1;
            alt_value[IDX_PORT3_BIT0] = div_clk;
        end
        // Bit1: oscillator input, never driven while claimed
        alt_en[IDX_PORT3_BIT1] = osc_input_sel;
    end

    // One driver cell per pin; unclaimed pins follow their latch
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        pin_mux_cell u_cell (
            .latch(latch[g]),
            .alt_en(alt_en[g]),
            .alt_drive(alt_drive[g]),
            .alt_value(alt_value[g]),
            .out(next_pin_out[g]),
            .oe(next_pin_oe[g]),
            .pull_en(next_pin_pullup[g])
        );
    end

    // Toggle every CPU clock for a divide by two
    always_comb begin
        next_div_clk = ~div_clk;
    end

    // All state and output flops
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            // Latches take input-only with pull-up off
            for (int i = 0; i < PIN_COUNT; i++) begin
                latch[i] <= PIN_CTL_RESET;
            end
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
            pin_read <= '0;
            spi_data_out_in <= 1'b0;
            spi_data_in_in <= 1'b0;
            spi_clock_in <= 1'b0;
            spi_select_n_in <= 1'b1;
            osc_input <= 1'b0;
            divided_clock_output_active <= 1'b0;
            div_clk <= 1'b0;
            fresh <= 1'b1;
        end else begin
            latch <= next_latch;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_pullup <= next_pin_pullup;
            pin_read <= PIN_IN;
            spi_data_out_in <= PIN_IN[IDX_PORT2_BIT2];
            spi_data_in_in <= PIN_IN[IDX_PORT2_BIT3];
            spi_clock_in <= PIN_IN[IDX_PORT2_BIT5];
            spi_select_n_in <= PIN_IN[IDX_PORT2_BIT4];
            osc_input <= osc_input_sel ? PIN_IN[IDX_PORT3_BIT1] : 1'b0;
            divided_clock_output_active <= divided_clock_output_sel;
            div_clk <= next_div_clk;
            fresh <= 1'b0;
        end
    end

    // Outputs straight from flops
    assign PIN_OUT = pin_out;
    assign PIN_OE = pin_oe;
    assign PIN_PULLUP = pin_pullup;
    assign PIN_READ = pin_read;
    assign SPI_DATA_OUT_IN = spi_data_out_in;
    assign SPI_DATA_IN_IN = spi_data_in_in;
    assign SPI_CLOCK_IN = spi_clock_in;
    assign SPI_SELECT_N_IN = spi_select_n_in;
    assign OSC_INPUT = osc_input;
    assign CLOCK_OUTPUT_ACTIVE = divided_clock_output_active;

    // Checks on the registered pin behaviour
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    // Data-in pin direction by role
    property p_data_in_dir;
        SPI_CTL.enable |=> (PIN_OE[IDX_PORT2_BIT3] == !$past(SPI_CTL.master)) &&
            ($past(SPI_CTL.master) ||
             PIN_OUT[IDX_PORT2_BIT3] == $past(SPI_CTL.data_in_drive));
    endproperty
    a_data_in_dir: assert property (p_data_in_dir)
        else $error("data-in pin direction wrong for role");

    // Clock pin driven by the device as master
    property p_clock_dir;
        SPI_CTL.enable && SPI_CTL.master |=> PIN_OE[IDX_PORT2_BIT5] &&
            PIN_OUT[IDX_PORT2_BIT5] == $past(SPI_CTL.clock_out);
    endproperty
    a_clock_dir: assert property (p_clock_dir)
        else $error("clock pin not driven as master");

    // Data-out pin released as slave
    property p_data_out_dir;
        SPI_CTL.enable && !SPI_CTL.master |=> !PIN_OE[IDX_PORT2_BIT2];
    endproperty
    a_data_out_dir: assert property (p_data_out_dir)
        else $error("data-out pin driven while slave");

    // Reset leaves port 3 latches input only with no pull-up
    property p_reset_state;
        fresh |-> latch[IDX_PORT3_BIT0].mode == MODE_INPUT_ONLY &&
            latch[IDX_PORT3_BIT1].mode == MODE_INPUT_ONLY &&
            PIN_PULLUP == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("port latch not input only after reset");

    // A write to bit0 leaves bit1 unchanged
    property p_independent;
        PORT_WR == 6'h10 |=> $stable(latch[IDX_PORT3_BIT1]) &&
            latch[IDX_PORT3_BIT0] == $past(PORT_WDATA);
    endproperty
    a_independent: assert property (p_independent)
        else $error("pin latch write disturbed another pin");

    // Divided clock toggles every cycle while selected
    property p_divided_clock_output_toggle;
        divided_clock_output_sel ##1 divided_clock_output_sel |=> PIN_OE[IDX_PORT3_BIT0] &&
            PIN_OUT[IDX_PORT3_BIT0] != $past(PIN_OUT[IDX_PORT3_BIT0]);
    endproperty
    a_divided_clock_output_toggle: assert property (p_divided_clock_output_toggle)
        else $error("divided clock not toggling on bit0");

    // Crystal system timer blocks the divided clock
    property p_divided_clock_output_block;
        RTC_FROM_CRYSTAL |=> !CLOCK_OUTPUT_ACTIVE;
    endproperty
    a_divided_clock_output_block: assert property (p_divided_clock_output_block)
        else $error("divided clock active with crystal timer");

    // Crystal option puts the amplifier output on bit0
    property p_amp_out;
        CPU_CLOCK_SOURCE == CLK_CRYSTAL |=> PIN_OE[IDX_PORT3_BIT0] &&
            PIN_OUT[IDX_PORT3_BIT0] == $past(OSC_AMP_OUT);
    endproperty
    a_amp_out: assert property (p_amp_out)
        else $error("amplifier output missing on bit0");

    // Oscillator input is never driven and reaches the clock path
    property p_osc_in;
        osc_input_sel |=> !PIN_OE[IDX_PORT3_BIT1] &&
            OSC_INPUT == $past(PIN_IN[IDX_PORT3_BIT1]);
    endproperty
    a_osc_in: assert property (p_osc_in)
        else $error("oscillator input pin misused");

    // Slave select sampled from its pin in every mode
    // Skipped on the release edge, where the flop still holds its reset value
    property p_select_in;
        !fresh |=> SPI_SELECT_N_IN == $past(PIN_IN[IDX_PORT2_BIT4]);
    endproperty
    a_select_in: assert property (p_select_in)
        else $error("slave select not following its pin");

    // Unclaimed push-pull pin follows its latch data
    property p_follow_latch;
        !SPI_CTL.enable && latch[IDX_PORT2_BIT2].mode == MODE_PUSH_PULL |=>
            PIN_OE[IDX_PORT2_BIT2] &&
            PIN_OUT[IDX_PORT2_BIT2] == $past(latch[IDX_PORT2_BIT2].data);
    endproperty
    a_follow_latch: assert property (p_follow_latch)
        else $error("idle pin not following its latch");

endmodule

/* testbench/pin_partner_model.sv */
// Far-side model: serial peer, clock source and board wiring of the shared pins
module pin_partner_model
    import pin_sharing_pkg::*;
(
    input wire logic clk,
    input wire logic [PIN_COUNT-1:0] drive_en,
    input wire logic [PIN_COUNT-1:0] drive_val,
    input wire logic [PIN_COUNT-1:0] dev_out,
    input wire logic [PIN_COUNT-1:0] dev_oe,
    input wire logic [PIN_COUNT-1:0] dev_pullup,
    output logic [PIN_COUNT-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PIN_COUNT-1:0] last = '0; // Last wire level, a floating wire flips it
    // Wire level from all parties; the peer yields where the device drives
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (dev_oe[i]) begin
                level[i] = dev_out[i];
            end else if (drive_en[i]) begin
                level[i] = drive_val[i];
            end else if (dev_pullup[i]) begin
                level[i] = 1'b1;
            end else begin
                level[i] = ~last[i];
            end
        end
    end
    // Remember the level so an undriven wire never holds still
    always @(posedge clk) begin
        last <= level;
    end
endmodule

/* testbench/test_spi_and_clock_pin_sharing.sv */
// Self-checking bench for the serial and clock pin sharing block
module test_spi_and_clock_pin_sharing
    import pin_sharing_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0; // 50 ns clock
    logic arst_n = 1'b0;
    logic [5:0] pin_in, pin_out, pin_oe, pin_pu, pin_read, rd;
    logic [5:0] port_wr = '0;
    logic [5:0] peer_en = '0;
    logic [5:0] peer_val = '0;
    pin_ctl_t port_wdata = PIN_CTL_RESET;
    spi_ctl_t spi_ctl = '0;
    logic [7:0] osc_trim = '0;
    clk_src_t src = CLK_INTERNAL_RC;
    logic rtc = 1'b0;
    logic amp = 1'b0;
    logic do_in, di_in, ck_in, sel_n_in, osc_in, ck_act, p, act, port;
    pin_ctl_t latch [6]; // Expected latch contents
    int miscompares = 0;
    int checks = 0;
    int seed = 62;

    spi_and_clock_pin_sharing spi_and_clock_pin_sharing_i (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu), .PIN_READ(pin_read), .PORT_WR(port_wr),
        .PORT_WDATA(port_wdata), .SPI_CTL(spi_ctl), .SPI_DATA_OUT_IN(do_in),
        .SPI_DATA_IN_IN(di_in), .SPI_CLOCK_IN(ck_in), .SPI_SELECT_N_IN(sel_n_in),
        .OSC_TRIM(osc_trim), .CPU_CLOCK_SOURCE(src), .RTC_FROM_CRYSTAL(rtc),
        .OSC_AMP_OUT(amp), .OSC_INPUT(osc_in), .CLOCK_OUTPUT_ACTIVE(ck_act));

    pin_partner_model pin_partner_model_i (.clk(sys_clk), .drive_en(peer_en),
        .drive_val(peer_val), .dev_out(pin_out), .dev_oe(pin_oe), .dev_pullup(pin_pu),
        .level(pin_in));

    // Clock generator
    always #25 sys_clk = ~sys_clk;

    // Expected {oe, pullup, out} of a pin left to its latch
    function automatic logic [2:0] exp_pin(pin_ctl_t c);
        case (c.mode)
            MODE_PUSH_PULL: return {1'b1, 1'b0, c.data};
            MODE_OPEN_DRAIN: return {~c.data, 2'b00};
            MODE_QUASI: return {~c.data, 2'b10};
            default: return 3'b000;
        endcase
    endfunction

    // Single comparison point
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    // Let one edge land, then look at mid-cycle
    task automatic settle();
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Every pin against its own latch
    task automatic check_ports();
        logic [5:0] eo, ep, ev;
        logic [2:0] e;
        for (int i = 0; i < 6; i++) begin
            e = exp_pin(latch[i]);
            eo[i] = e[2];
            ep[i] = e[1];
            ev[i] = e[0];
        end
        check({2'b00, pin_oe}, {2'b00, eo});
        check({2'b00, pin_pu}, {2'b00, ep});
        check({2'b00, pin_out & pin_oe}, {2'b00, ev});
    endtask

    // One strobe, pin shows the latch two edges later
    task automatic write_latch(int i, pin_ctl_t v);
        @(posedge sys_clk);
        port_wr <= 6'h01 << i;
        port_wdata <= v;
        @(posedge sys_clk);
        port_wr <= '0;
        latch[i] = v;
        settle();
    endtask

    // Pin levels return one edge later
    task automatic sample_read();
        rd = pin_in;
        settle();
        check({2'b00, pin_read}, {2'b00, rd});
        check({4'h0, sel_n_in, ck_in, di_in, do_in}, {4'h0, rd[2], rd[3], rd[1], rd[0]});
    endtask

    // Reset pulse, then all pins undriven without pull-up
    task automatic reset_dut(int n);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        arst_n <= 1'b1;
        foreach (latch[i]) latch[i] = PIN_CTL_RESET;
        settle();
        check({pin_oe, 2'b00}, 8'h00);
        check({pin_pu, 2'b00}, 8'h00);
        check_ports();
    endtask

    task automatic done_test(string name);
        $display("test %s finished", name);
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_dut(20);
        done_test("reset");
        repeat (24) begin // Random latches with a random peer
            @(posedge sys_clk);
            peer_en <= 6'($random(seed));
            peer_val <= 6'($random(seed));
            write_latch(int'($unsigned($random(seed)) % 6), pin_ctl_t'(3'($random(seed))));
            check_ports();
            sample_read();
        end
        done_test("latches");
        write_latch(IDX_PORT2_BIT4, '{mode: MODE_PUSH_PULL, data: 1'b0});
        for (int k = 0; k < 8; k++) begin // Master and slave in turn
            @(posedge sys_clk);
            spi_ctl <= spi_ctl_t'({1'b1, k[0], 3'($random(seed))});
            settle();
            check({4'h0, pin_oe[3], pin_oe[0], pin_oe[2], pin_oe[1]},
                  {4'h0, k[0], k[0], 1'b1, ~k[0]});
            if (k[0]) begin
                check({6'h00, pin_out[3], pin_out[0]},
                      {6'h00, spi_ctl.clock_out, spi_ctl.data_out});
            end else begin
                check({7'h00, pin_out[1]}, {7'h00, spi_ctl.data_in_drive});
            end
            sample_read();
        end
        @(posedge sys_clk);
        spi_ctl <= '0;
        settle();
        check_ports();
        done_test("serial");
        write_latch(IDX_PORT3_BIT1, '{mode: MODE_PUSH_PULL, data: 1'b1});
        for (int s = 0; s < 8; s++) begin // Every source, with and without crystal timer
            @(posedge sys_clk);
            src <= clk_src_t'(s[1:0]);
            rtc <= s[2];
            amp <= s[0];
            osc_trim <= 8'($random(seed)) | 8'h40;
            peer_en <= 6'h3f;
            peer_val <= 6'($random(seed));
            settle();
            act = s[1:0] != 2'b11 && !s[2];
            port = !s[1] && !s[2];
            check({7'h00, ck_act}, {7'h00, act});
            check({7'h00, pin_oe[4]}, 8'h01);
            p = pin_out[4];
            if (act) begin
                @(negedge sys_clk);
                check({6'h00, pin_out[4], p}, {6'h00, ~p, p});
            end else begin
                check({7'h00, p}, {7'h00, amp});
            end
            check({7'h00, pin_oe[5]}, {7'h00, port});
            rd = pin_in;
            settle();
            check({7'h00, osc_in}, {7'h00, rd[5] & ~port});
        end
        @(posedge sys_clk);
        osc_trim <= 8'h00;
        src <= CLK_INTERNAL_RC;
        rtc <= 1'b0;
        settle();
        check({7'h00, ck_act}, 8'h00);
        check_ports();
        done_test("clock");
        reset_dut(3);
        done_test("second reset");
        stop_test();
    end

    // Watchdog against a hang
    initial begin
        #200_000;
        miscompares++;
        stop_test();
    end
endmodule
